// ===== rtl/cfg_word_pkg.sv
// constants and field layout for the configuration word decoder
package cfg_word_pkg;
    localparam int WORD_W = 24;
    // register addresses on the plain register port
    localparam logic [3:0] ADDR_WORD = 4'h0; // live configuration word
    localparam logic [3:0] ADDR_PROG_WORD = 4'h1; // programmer write of word
    localparam logic [3:0] ADDR_DONE = 4'h2; // program-once marks
    localparam logic [3:0] ADDR_WDT_DIV = 4'h3; // decoded watchdog divide
    // field positions
    localparam int BIT_RSVD = 15;
    localparam int BIT_TEST_PORT = 14;
    localparam int BIT_CODE_PROT = 13;
    localparam int BIT_WRITE_PROT = 12;
    localparam int BIT_DEBUG_N = 11;
    localparam int BIT_PIN_SEL_LO = 8;
    localparam int BIT_WD_EN = 7;
    localparam int BIT_WIN_DIS = 6;
    localparam int BIT_PRESCALE = 4;
    localparam int BIT_POST_LO = 0;
    // writable bits: 14..11, 9..8, 7, 6, 4, 3..0
    localparam logic [23:0] WRITABLE_MASK = 24'h007BDF;
    // unimplemented bits read as one: 23..16, 10, 5
    localparam logic [23:0] UNIMPL_ONES = 24'hFF0420;
    // unprogrammed value: every writable and unimplemented bit one
    localparam logic [23:0] ERASED_WORD = 24'hFF7FFF;
    localparam logic [7:0] PRESCALE_LOG_HI = 8'h07; // 1:128
    localparam logic [7:0] PRESCALE_LOG_LO = 8'h05; // 1:32
    localparam logic [15:0] POST_RATIO_MAX = 16'h8000; // largest postscale
    localparam logic [1:0] PIN_PAIR_ONE = 2'h3;
    localparam logic [1:0] PIN_PAIR_TWO = 2'h2;
    localparam logic [1:0] PIN_PAIR_THREE = 2'h1;
    localparam logic [1:0] PIN_PAIR_RSVD = 2'h0;
endpackage

// ===== rtl/cfg_once_bit.sv
// one program-once configuration cell
`timescale 1ns/1ps
`default_nettype none
module cfg_once_bit (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic write_in,
    input wire logic value_in,
    output logic value_out,
    output logic done_out
);
    logic value_q;
    logic done_q;
    // first write sticks, later writes are ignored
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            value_q <= 1'b1;
            done_q <= 1'b0;
        end else if (write_in && !done_q) begin
            value_q <= value_in;
            done_q <= 1'b1;
        end
    end
    assign value_out = value_q;
    assign done_out = done_q;
endmodule
`default_nettype wire

// ===== rtl/cfg_postscale_decode.sv
// postscaler code to one-hot divide ratio
`timescale 1ns/1ps
`default_nettype none
module cfg_postscale_decode (
    input wire logic [3:0] code_in,
    output logic [15:0] ratio_out
);
    // ratio is two raised to the code
    assign ratio_out = 16'h0001 << code_in;
endmodule
`default_nettype wire

// ===== rtl/config_word_one_decoder.sv
// decoder for nonvolatile configuration word one
`timescale 1ns/1ps
`default_nettype none
module config_word_one_decoder (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [3:0] addr_in,
    input wire logic [23:0] wdata_in,
    input wire logic write_in,
    input wire logic read_in,
    input wire logic via_scan_in,
    output logic [23:0] rdata_out,
    output logic test_port_enable_out,
    output logic code_protect_out,
    output logic program_write_block_out,
    output logic debug_mode_out,
    output logic prog_pin_pair_one_out,
    output logic prog_pin_pair_two_out,
    output logic prog_pin_pair_three_out,
    output logic pin_select_bad_out,
    output logic watchdog_enable_out,
    output logic watchdog_window_out,
    output logic window_conflict_out,
    output logic [7:0] wd_prescale_log_out,
    output logic [15:0] wd_postscale_ratio_out
);
    // ------------------------------------------------------------
    // nonvolatile cells
    // ------------------------------------------------------------
    logic [23:0] cell_val;
    logic [23:0] cell_done;
    logic prog_wr;
    logic scan_q1;
    logic scan_q2;
    logic [23:0] nv_word;
    logic [23:0] live_q;
    logic [23:0] live_d;
    logic captured_q;

    // scan source flag comes from a pin, so synchronise it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scan_q1 <= 1'b0;
            scan_q2 <= 1'b0;
        end else begin
            scan_q1 <= via_scan_in;
            scan_q2 <= scan_q1;
        end
    end

    assign prog_wr = write_in && (addr_in == cfg_word_pkg::ADDR_PROG_WORD);

    // one program-once cell per writable bit
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_cell
            if (cfg_word_pkg::WRITABLE_MASK[gi]) begin : g_wr
                logic wr_bit;
                // test-port bit refuses scan writes
                if (gi == cfg_word_pkg::BIT_TEST_PORT) begin : g_tp
                    assign wr_bit = prog_wr && !scan_q2;
                end else begin : g_ot
                    assign wr_bit = prog_wr;
                end
                cfg_once_bit u_cell (
                    .clock_in(clock_in),
                    .resetn_in(resetn_in),
                    .write_in(wr_bit),
                    .value_in(wdata_in[gi]),
                    .value_out(cell_val[gi]),
                    .done_out(cell_done[gi])
                );
                // a first write lands with its data, a later one is dropped
                AST_CELL_TAKES: assert property (@(posedge clock_in)
                    disable iff (!resetn_in) wr_bit && !cell_done[gi] |=>
                    cell_done[gi] && cell_val[gi] == $past(wdata_in[gi]))
                    else $error("first programming write lost");
                AST_CELL_ONCE: assert property (@(posedge clock_in)
                    disable iff (!resetn_in) cell_done[gi] |=>
                    cell_done[gi] && $stable(cell_val[gi]))
                    else $error("programmed cell changed");
            end else begin : g_fix
                // unimplemented ones, reserved bit left as zero
                assign cell_val[gi] = cfg_word_pkg::UNIMPL_ONES[gi];
                assign cell_done[gi] = 1'b0;
            end
        end
    endgenerate

    assign nv_word = cell_val;

    // ------------------------------------------------------------
    // capture at reset release, then hold
    // ------------------------------------------------------------
    always_comb begin
        live_d = live_q;
        if (!captured_q) begin
            live_d = nv_word | cfg_word_pkg::UNIMPL_ONES;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            live_q <= cfg_word_pkg::ERASED_WORD;
            captured_q <= 1'b0;
        end else begin
            live_q <= live_d;
            captured_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // decoded settings
    // ------------------------------------------------------------
    logic [1:0] pin_sel;
    logic [15:0] post_ratio;
    assign pin_sel = live_q[cfg_word_pkg::BIT_PIN_SEL_LO +: 2];

    cfg_postscale_decode u_post (
        .code_in(live_q[cfg_word_pkg::BIT_POST_LO +: 4]),
        .ratio_out(post_ratio)
    );

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            test_port_enable_out <= 1'b1;
            code_protect_out <= 1'b0;
            program_write_block_out <= 1'b0;
            debug_mode_out <= 1'b0;
            prog_pin_pair_one_out <= 1'b1;
            prog_pin_pair_two_out <= 1'b0;
            prog_pin_pair_three_out <= 1'b0;
            pin_select_bad_out <= 1'b0;
            watchdog_enable_out <= 1'b1;
            watchdog_window_out <= 1'b0;
            window_conflict_out <= 1'b0;
            wd_prescale_log_out <= cfg_word_pkg::PRESCALE_LOG_HI;
            wd_postscale_ratio_out <= cfg_word_pkg::POST_RATIO_MAX;
        end else begin
            test_port_enable_out <= live_q[cfg_word_pkg::BIT_TEST_PORT];
            code_protect_out <= !live_q[cfg_word_pkg::BIT_CODE_PROT];
            program_write_block_out <=
                !live_q[cfg_word_pkg::BIT_WRITE_PROT];
            debug_mode_out <= !live_q[cfg_word_pkg::BIT_DEBUG_N];
            prog_pin_pair_one_out <=
                (pin_sel == cfg_word_pkg::PIN_PAIR_ONE);
            prog_pin_pair_two_out <=
                (pin_sel == cfg_word_pkg::PIN_PAIR_TWO);
            prog_pin_pair_three_out <=
                (pin_sel == cfg_word_pkg::PIN_PAIR_THREE);
            pin_select_bad_out <=
                (pin_sel == cfg_word_pkg::PIN_PAIR_RSVD);
            watchdog_enable_out <= live_q[cfg_word_pkg::BIT_WD_EN];
            watchdog_window_out <= !live_q[cfg_word_pkg::BIT_WIN_DIS];
            // windowed mode without watchdog enable is a programming fault
            window_conflict_out <= !live_q[cfg_word_pkg::BIT_WIN_DIS]
                && !live_q[cfg_word_pkg::BIT_WD_EN];
            wd_prescale_log_out <= live_q[cfg_word_pkg::BIT_PRESCALE]
                ? cfg_word_pkg::PRESCALE_LOG_HI
                : cfg_word_pkg::PRESCALE_LOG_LO;
            wd_postscale_ratio_out <= post_ratio;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 24'h000000;
        end else if (read_in) begin
            unique case (addr_in)
                cfg_word_pkg::ADDR_WORD: rdata_out <= live_q;
                cfg_word_pkg::ADDR_PROG_WORD: rdata_out <= nv_word;
                cfg_word_pkg::ADDR_DONE: rdata_out <= cell_done;
                cfg_word_pkg::ADDR_WDT_DIV: begin
                    rdata_out <= {wd_prescale_log_out, post_ratio};
                end
                default: rdata_out <= 24'h000000;
            endcase
        end else begin
            rdata_out <= 24'h000000;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_prog_write(int b);
        prog_wr && cell_done[b];
    endsequence

    AST_LIVE_HOLDS: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> $stable(live_q))
        else $error("live word changed after capture");
    AST_UNIMPL_ONES: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        (live_q & cfg_word_pkg::UNIMPL_ONES) == cfg_word_pkg::UNIMPL_ONES)
        else $error("unimplemented bit not one");
    AST_TEST_PORT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        test_port_enable_out == $past(live_q[14]))
        else $error("test port enable mismatch");
    AST_SCAN_REFUSED: assert property (@(posedge clock_in)
        disable iff (!resetn_in) prog_wr && scan_q2 |=> $stable(cell_val[14]))
        else $error("scan write changed test port bit");
    AST_ONCE: assert property (@(posedge clock_in)
        disable iff (!resetn_in) s_prog_write(3) |=> $stable(cell_val[3]))
        else $error("programmed field changed");
    AST_CODE_PROT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        code_protect_out == !$past(live_q[13]))
        else $error("code protect mismatch");
    AST_WRITE_PROT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        program_write_block_out == !$past(live_q[12]))
        else $error("write protect mismatch");
    AST_DEBUG: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        debug_mode_out == !$past(live_q[11]))
        else $error("debug mode mismatch");
    AST_PIN_ONEHOT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) $onehot({prog_pin_pair_one_out,
        prog_pin_pair_two_out, prog_pin_pair_three_out, pin_select_bad_out}))
        else $error("pin pair select not one-hot");
    AST_WD_EN: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        watchdog_enable_out == $past(live_q[7]))
        else $error("watchdog enable mismatch");
    AST_WINDOW: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        watchdog_window_out == !$past(live_q[6]))
        else $error("window mode mismatch");
    AST_PRESCALE: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q && live_q[4] |=>
        wd_prescale_log_out == 8'h07)
        else $error("prescale not 128");
    AST_POSTSCALE: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=>
        wd_postscale_ratio_out == (16'h0001 << $past(live_q[3:0])))
        else $error("postscale ratio wrong");

    // ------------------------------------------------------------
    // capture and unprogrammed defaults
    // ------------------------------------------------------------
    // first sampled cycle after the capture edge
    sequence s_captured;
        $rose(captured_q);
    endsequence

    // the capture flag drops only with reset
    AST_CAPTURE_STAYS: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> captured_q)
        else $error("capture flag dropped");
    // cells are reset with the block, so a capture sees them blank
    AST_CAPTURE_ERASED: assert property (@(posedge clock_in)
        disable iff (!resetn_in) s_captured |->
        live_q == cfg_word_pkg::ERASED_WORD)
        else $error("captured word not the unprogrammed value");
    // before the first decode the outputs still hold the blank settings
    AST_RESET_FLAGS: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !captured_q |->
        test_port_enable_out && !code_protect_out
        && !program_write_block_out && !debug_mode_out
        && prog_pin_pair_one_out && watchdog_enable_out
        && !watchdog_window_out && !window_conflict_out)
        else $error("setting not blank before capture");
    AST_RESET_SCALES: assert property (@(posedge clock_in)
        disable iff (!resetn_in) !captured_q |->
        wd_prescale_log_out == cfg_word_pkg::PRESCALE_LOG_HI
        && wd_postscale_ratio_out == cfg_word_pkg::POST_RATIO_MAX)
        else $error("watchdog divide not blank before capture");

    // ------------------------------------------------------------
    // decode of each field
    // ------------------------------------------------------------
    AST_PIN_ONE: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> prog_pin_pair_one_out ==
        ($past(pin_sel) == cfg_word_pkg::PIN_PAIR_ONE))
        else $error("pin pair one select wrong");
    AST_PIN_TWO: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> prog_pin_pair_two_out ==
        ($past(pin_sel) == cfg_word_pkg::PIN_PAIR_TWO))
        else $error("pin pair two select wrong");
    AST_PIN_THREE: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> prog_pin_pair_three_out ==
        ($past(pin_sel) == cfg_word_pkg::PIN_PAIR_THREE))
        else $error("pin pair three select wrong");
    AST_PIN_BAD: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> pin_select_bad_out ==
        ($past(pin_sel) == cfg_word_pkg::PIN_PAIR_RSVD))
        else $error("reserved pin select not flagged");
    // windowed mode with the watchdog off is flagged, never hidden
    AST_CONFLICT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) captured_q |=> window_conflict_out ==
        (!$past(live_q[cfg_word_pkg::BIT_WIN_DIS])
        && !$past(live_q[cfg_word_pkg::BIT_WD_EN])))
        else $error("window conflict flag wrong");
    AST_PRESCALE_LO: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        captured_q && !live_q[cfg_word_pkg::BIT_PRESCALE] |=>
        wd_prescale_log_out == cfg_word_pkg::PRESCALE_LOG_LO)
        else $error("prescale not 32");
    // exactly one ratio bit, so the divide is a power of two
    AST_POST_ONEHOT: assert property (@(posedge clock_in)
        disable iff (!resetn_in) $onehot(wd_postscale_ratio_out))
        else $error("postscale ratio not a power of two");

    // ------------------------------------------------------------
    // programming path and read-back
    // ------------------------------------------------------------
    // a scan write leaves the test-port cell unprogrammed
    AST_SCAN_NOT_DONE: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        prog_wr && scan_q2 && !cell_done[cfg_word_pkg::BIT_TEST_PORT] |=>
        !cell_done[cfg_word_pkg::BIT_TEST_PORT])
        else $error("scan write programmed the test port cell");
    // scan flag passes both flops before the write gate reads it
    AST_SCAN_SYNC: assert property (@(posedge clock_in)
        disable iff (!resetn_in) scan_q2 == $past(scan_q1))
        else $error("scan flag synchroniser out of step");
    // stored word keeps its fixed ones and a zero reserved bit
    AST_STORED_FIXED: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        (nv_word & cfg_word_pkg::UNIMPL_ONES) == cfg_word_pkg::UNIMPL_ONES
        && !nv_word[cfg_word_pkg::BIT_RSVD])
        else $error("fixed bit of stored word wrong");
    // live word read-back shows the held word with its fixed ones
    AST_READ_LIVE: assert property (@(posedge clock_in)
        disable iff (!resetn_in)
        read_in && addr_in == cfg_word_pkg::ADDR_WORD |=>
        rdata_out == $past(live_q) && (rdata_out & cfg_word_pkg::UNIMPL_ONES)
        == cfg_word_pkg::UNIMPL_ONES)
        else $error("live word read-back wrong");
endmodule
`default_nettype wire

// ===== bench/cfg_programmer_model.sv
// programmer model that writes the configuration word
`timescale 1ns/1ps
`default_nettype none
module cfg_programmer_model (
    input wire logic clock_in,
    output logic [3:0] addr_out,
    output logic [23:0] wdata_out,
    output logic write_out,
    output logic via_scan_out
);
    // idle bus at time zero
    initial begin
        addr_out = 4'h0;
        wdata_out = 24'h000000;
        write_out = 1'b0;
        via_scan_out = 1'b0;
    end

    // one programming write, scan path raised well ahead of the strobe
    task automatic program_word(input logic [23:0] word, input logic scan);
        logic [23:0] w;
        begin
            w = word;
            w[cfg_word_pkg::BIT_RSVD] = 1'b0;
            if (!w[cfg_word_pkg::BIT_WIN_DIS]) begin
                w[cfg_word_pkg::BIT_WD_EN] = 1'b1;
            end
            @(posedge clock_in);
            via_scan_out <= scan;
            repeat (3) @(posedge clock_in);
            addr_out <= cfg_word_pkg::ADDR_PROG_WORD;
            wdata_out <= w;
            write_out <= 1'b1;
            @(posedge clock_in);
            write_out <= 1'b0;
            via_scan_out <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/test_config_word_one_decoder.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("BAD %s expected %h seen %h", name, exp, got); end end
module test_config_word_one_decoder;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] tb_addr = 4'h0;
    logic read_in = 1'b0;
    logic [3:0] p_addr;
    logic [23:0] wdata;
    logic write_in;
    logic via_scan;
    logic [3:0] addr_in;
    logic [23:0] rdata_out;
    logic [34:0] dec;
    logic [23:0] rd;
    int err_count = 0;
    int n_tests = 0;

    // ---------------------------------------------------------------
    // clock, bus sharing and instances
    // ---------------------------------------------------------------
    always #5 clock_in = ~clock_in;
    // programmer owns the address only while it strobes a write
    assign addr_in = write_in ? p_addr : tb_addr;

    cfg_programmer_model cfg_programmer_model_inst (
        .clock_in(clock_in), .addr_out(p_addr), .wdata_out(wdata),
        .write_out(write_in), .via_scan_out(via_scan));

    config_word_one_decoder config_word_one_decoder_inst (
        .clock_in(clock_in), .resetn_in(resetn_in), .addr_in(addr_in),
        .wdata_in(wdata), .write_in(write_in), .read_in(read_in),
        .via_scan_in(via_scan), .rdata_out(rdata_out),
        .test_port_enable_out(dec[34]), .code_protect_out(dec[33]),
        .program_write_block_out(dec[32]), .debug_mode_out(dec[31]),
        .prog_pin_pair_one_out(dec[30]), .prog_pin_pair_two_out(dec[29]),
        .prog_pin_pair_three_out(dec[28]), .pin_select_bad_out(dec[27]),
        .watchdog_enable_out(dec[26]), .watchdog_window_out(dec[25]),
        .window_conflict_out(dec[24]), .wd_prescale_log_out(dec[23:16]),
        .wd_postscale_ratio_out(dec[15:0]));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    // one-cycle read, data taken in the single cycle it stands
    task automatic reg_read(input logic [3:0] a, output logic [23:0] d);
        @(posedge clock_in);
        tb_addr <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    // unprogrammed settings: port on, open, normal, pair one, watchdog on
    task automatic check_defaults;
        `CHECK("decoded", {11'b100_0100_0100, cfg_word_pkg::PRESCALE_LOG_HI,
            16'h8000}, dec)
    endtask

    task automatic do_reset(input int n);
        @(posedge clock_in);
        resetn_in <= 1'b0;
        repeat (n) @(posedge clock_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clock_in);
    endtask

    task automatic results;
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        do_reset(16);
        #1 check_defaults();
        reg_read(cfg_word_pkg::ADDR_WDT_DIV, rd);
        `CHECK("div", {cfg_word_pkg::PRESCALE_LOG_HI, 16'h8000}, rd)
        reg_read(cfg_word_pkg::ADDR_WORD, rd);
        `CHECK("live word", cfg_word_pkg::ERASED_WORD, rd)
        @(posedge clock_in);
        #1 `CHECK("rdata after", 24'h000000, rdata_out)
        reg_read(4'h4, rd);
        `CHECK("unmapped", 24'h000000, rd)
        // scan path: every field but the test-port and watchdog-enable ones takes zero
        cfg_programmer_model_inst.program_word(24'h000000, 1'b1);
        reg_read(cfg_word_pkg::ADDR_PROG_WORD, rd);
        `CHECK("scan write", 24'hFF44A0, rd)
        reg_read(cfg_word_pkg::ADDR_DONE, rd);
        `CHECK("marks scan", 24'h003BDF, rd)
        // serial path reaches the test-port field
        cfg_programmer_model_inst.program_word(24'h000000, 1'b0);
        reg_read(cfg_word_pkg::ADDR_PROG_WORD, rd);
        `CHECK("serial write", 24'hFF04A0, rd)
        reg_read(cfg_word_pkg::ADDR_DONE, rd);
        `CHECK("marks serial", cfg_word_pkg::WRITABLE_MASK, rd)
        // programmed cells refuse to return to one
        cfg_programmer_model_inst.program_word(24'hFFFFFF, 1'b0);
        reg_read(cfg_word_pkg::ADDR_PROG_WORD, rd);
        `CHECK("once", 24'hFF04A0, rd)
        // live word and settings untouched by programming activity
        reg_read(cfg_word_pkg::ADDR_WORD, rd);
        `CHECK("live held", cfg_word_pkg::ERASED_WORD, rd)
        check_defaults();
        // reset in mid-run brings everything back unprogrammed
        do_reset(2);
        #1 check_defaults();
        reg_read(cfg_word_pkg::ADDR_PROG_WORD, rd);
        `CHECK("erased again", cfg_word_pkg::ERASED_WORD, rd)
        reg_read(cfg_word_pkg::ADDR_DONE, rd);
        `CHECK("marks cleared", 24'h000000, rd)
        results();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #20000;
        err_count++;
        results();
    end
endmodule
`default_nettype wire
